// ===== ctp_channel_ctrl.sv
// Channel power, ramp and trip control for one multichannel supply board.
// Assumes a synchronous reset, Avalon-MM slave and external monitor inputs.
// Contract
// [RULE_01] Lower ceiling clamps active setpoint down
// [RULE_02] Power on needs no interlock, enabled
// [RULE_03] Programmable over-current trip time per channel
// [RULE_04] Two setpoints, two limits, selectable
// [RULE_05] Temperature outside thresholds flags over-temperature
// [RULE_06] Restore option keeps previous power state
// [RULE_07] Without restore channels start switched off
// [RULE_08] Immediate shutdown on trip drops instantly
// [RULE_09] Ramped shutdown falls at fall rate
// [RULE_10] Rise limited by programmed rise rate
// [RULE_11] Fall limited by programmed fall rate
// [RULE_12] Trip lines equal half channel count
// [RULE_13] Two-bit mode: drive, sense, both, none
// [RULE_14] Default pairing is unconnected
// [RULE_15] Sensing channel trips on line trip
// [RULE_16] Trip reaches sensers within one millisecond
// [RULE_17] No external trip input or output
// [RULE_18] Setpoint writes keep factory presets intact
// [RULE_19] Line is OR of driving channels
`timescale 1ns/10ps
`default_nettype none
module ctp_channel_ctrl
    import ctp_pkg::*;
(
    input  wire logic                 clk_sys,          // System clock
    input  wire logic                 rst,              // Sync reset, high
    input  wire logic [7:0]           avsAddress,       // Byte address
    input  wire logic                 avsRead,          // Read request
    input  wire logic                 avsWrite,         // Write request
    input  wire logic [31:0]          avsWriteData,     // Write data
    input  wire logic [3:0]           avsByteEnable,    // Byte enables
    output var  logic [31:0]          avsReadData,      // Read data
    output var  logic                 avsWaitRequest,   // Wait request
    input  wire logic                 interlockIn,      // Interlock pin
    input  wire logic [NUM_CH-1:0]    chanEnableIn,     // Local/remote enable
    input  wire logic [NUM_CH-1:0]    overCurrentIn,    // Over-current pins
    input  wire logic [VW-1:0]        tempIn,           // Board temperature
    output var  logic [NUM_CH*VW-1:0] voltageTarget,    // Ramped output targets
    output var  logic [NUM_CH*VW-1:0] currentLimit,     // Active current limits
    output var  logic [NUM_CH-1:0]    chanOn,           // Channel on
    output var  logic [NUM_LINES-1:0] tripLines,        // Internal trip bus
    output var  logic                 overTemp,         // Over-temperature
    output var  logic                 irq               // Level interrupt
);
    // Channel settings and ramp state
    ctp_chcfg_type           cfg_r    [NUM_CH];
    logic [VW-1:0]           vOut_r   [NUM_CH];
    logic [31:0]             ocCnt_r  [NUM_CH];
    logic [NUM_CH-1:0]       tripped_r;
    logic [NUM_CH-1:0]       pwrMem_r;

    // Board settings
    logic [2*NUM_LINES*NUM_CH-1:0] busCfg_r;
    logic [VW-1:0]           low_temperature_threshold_r, high_temperature_threshold_r;
    logic [VW-1:0]           presetV_r;

    // Time base, events, handshake
    logic [15:0]             tickCnt_r;
    logic                    tick_r;
    logic [7:0]              irqSt_r, irqMask_r;
    logic                    ack_r;

    // Pin synchronisers
    logic [1:0]              ilkSync_r;
    logic [NUM_CH-1:0]       enS0_r, enS1_r, ocS0_r, ocS1_r;
    logic [VW-1:0]           tS0_r, tS1_r;

    // Trip bus nets
    logic [NUM_LINES-1:0]    lineNxt;
    logic [NUM_CH-1:0]       sensedTrip;
    logic [NUM_CH-1:0]       tripNew;

    function automatic ctp_tbmode_type busMode(input int ch, input int ln);
        busMode = ctp_tbmode_type'(busCfg_r[2*(ch*NUM_LINES+ln) +: 2]);
    endfunction

    function automatic logic [VW-1:0] activeSet(input ctp_chcfg_type c);
        activeSet = c.vSel ? c.vsetB : c.vsetA; // RULE_04
    endfunction

    function automatic logic [2:0] chIdx(input logic [7:0] a);
        chIdx = a[7:5] - 3'(CH_BASE >> 5);
    endfunction

    // Pins from outside cross two flops before use
    always_ff @(posedge clk_sys) begin
        ilkSync_r <= {ilkSync_r[0], interlockIn};
        enS0_r    <= chanEnableIn;
        enS1_r    <= enS0_r;
        ocS0_r    <= overCurrentIn;
        ocS1_r    <= ocS0_r;
        tS0_r     <= tempIn;
        tS1_r     <= tS0_r;
    end

    // Ramp time base, one step per microsecond
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tickCnt_r <= '0;
            tick_r    <= 1'b0;
        end else if (tickCnt_r == 16'(TICK_CYCLES - 1)) begin
            tickCnt_r <= '0;
            tick_r    <= 1'b1;
        end else begin
            tickCnt_r <= tickCnt_r + 16'h0001;
            tick_r    <= 1'b0;
        end
    end

    // Line OR of driving channels, sense is combinational: one cycle latency
    always_comb begin
        lineNxt    = '0;
        sensedTrip = '0;
        for (int l = 0; l < NUM_LINES; l++) begin // RULE_12
            for (int c = 0; c < NUM_CH; c++) begin
                if (busMode(c, l) == TB_DRIVE || busMode(c, l) == TB_BOTH) begin // RULE_13
                    lineNxt[l] = lineNxt[l] | tripped_r[c]; // RULE_19
                end
            end
        end
        for (int c = 0; c < NUM_CH; c++) begin
            for (int l = 0; l < NUM_LINES; l++) begin
                if (busMode(c, l) == TB_SENSE || busMode(c, l) == TB_BOTH) begin
                    sensedTrip[c] = sensedTrip[c] | tripLines[l]; // RULE_15
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tripLines <= '0;
        end else begin
            tripLines <= lineNxt; // RULE_16 RULE_17
        end
    end

    // Over-current timers and trip latches
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            tripNew[c] = chanOn[c] && ((ocS1_r[c] && ocCnt_r[c] >= 32'(cfg_r[c].tripTime) * 32'(TICK_CYCLES))
                         || sensedTrip[c]);
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (rst) begin
                ocCnt_r[c]   <= '0;
                tripped_r[c] <= 1'b0;
            end else begin
                ocCnt_r[c] <= (ocS1_r[c] && chanOn[c]) ? ocCnt_r[c] + 32'h1 : '0; // RULE_03
                // Trip holds until the output reached zero
                if (tripNew[c]) begin
                    tripped_r[c] <= 1'b1;
                end else if (!chanOn[c] && vOut_r[c] == '0) begin
                    tripped_r[c] <= 1'b0;
                end
            end
        end
    end

    // Power state and the channel-on output
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (rst) begin
                chanOn[c] <= 1'b0;
            end else if (tripNew[c] || ilkSync_r[1] || !enS1_r[c]) begin
                chanOn[c] <= 1'b0;
            end else begin
                chanOn[c] <= cfg_r[c].pwr; // RULE_02
            end
        end
    end

    // Ramped output voltage
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            logic [VW-1:0] goal;
            goal = chanOn[c] ? activeSet(cfg_r[c]) : '0;

            if (rst) begin
                vOut_r[c] <= '0;
            end else if (tripped_r[c] && !cfg_r[c].rampDown) begin
                vOut_r[c] <= '0; // RULE_08
            end else if (tick_r) begin
                if (goal > vOut_r[c]) begin
                    vOut_r[c] <= (goal - vOut_r[c] > cfg_r[c].riseRate) ?
                                 vOut_r[c] + cfg_r[c].riseRate : goal; // RULE_10
                end else if (goal < vOut_r[c]) begin
                    vOut_r[c] <= (vOut_r[c] - goal > cfg_r[c].fallRate) ?
                                 vOut_r[c] - cfg_r[c].fallRate : goal; // RULE_11 RULE_09
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            voltageTarget[c*VW +: VW] <= rst ? '0 : vOut_r[c];
            currentLimit[c*VW +: VW]  <= rst ? '0 :
                (cfg_r[c].iSel ? cfg_r[c].ilimB : cfg_r[c].ilimA); // RULE_04
        end
    end

    // Over-temperature window check
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overTemp <= 1'b0;
        end else begin
            overTemp <= (tS1_r < low_temperature_threshold_r) || (tS1_r > high_temperature_threshold_r); // RULE_05
        end
    end

    // Register file; pwrMem_r survives reset to model retained power state
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (rst) begin
                pwrMem_r[c] <= pwrMem_r[c];
            end else begin
                pwrMem_r[c] <= cfg_r[c].pwr;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_r[c]         <= '0;
                cfg_r[c].ceil    <= '1;
                cfg_r[c].restore <= cfg_r[c].restore;
                // Unknown restore bit at power-up counts as off
                if (cfg_r[c].restore) begin
                    cfg_r[c].pwr <= pwrMem_r[c]; // RULE_06
                end else begin
                    cfg_r[c].pwr <= 1'b0; // RULE_07
                end
            end
            busCfg_r <= '0; // RULE_14
            low_temperature_threshold_r   <= '0;
            high_temperature_threshold_r   <= '1;
        end else if (avsWrite && !ack_r) begin
            // Writes land on the request edge
            if (avsAddress == A_TEMP_LIM) begin
                low_temperature_threshold_r <= avsWriteData[15:0];
                high_temperature_threshold_r <= avsWriteData[31:16];
            end else if (avsAddress == A_BUS_CFG) begin
                busCfg_r <= avsWriteData[2*NUM_LINES*NUM_CH-1:0];
            end else if (avsAddress >= CH_BASE) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (avsAddress[7:5] == 3'(c + (CH_BASE >> 5))) begin
                        if (avsAddress[4:0] == F_VSET_A) begin
                            cfg_r[c].vsetA <= (avsWriteData[15:0] > cfg_r[c].ceil) ? cfg_r[c].ceil
                                                                              : avsWriteData[15:0];
                        end else if (avsAddress[4:0] == F_VSET_B) begin
                            cfg_r[c].vsetB <= (avsWriteData[15:0] > cfg_r[c].ceil) ? cfg_r[c].ceil
                                                                              : avsWriteData[15:0];
                        end else if (avsAddress[4:0] == F_ILIM_A) begin
                            cfg_r[c].ilimA <= avsWriteData[15:0];
                        end else if (avsAddress[4:0] == F_ILIM_B) begin
                            cfg_r[c].ilimB <= avsWriteData[15:0];
                        end else if (avsAddress[4:0] == F_CEIL) begin
                            cfg_r[c].ceil <= avsWriteData[15:0];
                            if (cfg_r[c].vsetA > avsWriteData[15:0]) begin
                                cfg_r[c].vsetA <= avsWriteData[15:0]; // RULE_01
                            end
                            if (cfg_r[c].vsetB > avsWriteData[15:0]) begin
                                cfg_r[c].vsetB <= avsWriteData[15:0]; // RULE_01
                            end
                        end else if (avsAddress[4:0] == F_RATES) begin
                            cfg_r[c].riseRate <= avsWriteData[15:0];
                            cfg_r[c].fallRate <= avsWriteData[31:16];
                        end else if (avsAddress[4:0] == F_CTRL) begin
                            cfg_r[c].pwr      <= avsWriteData[C_PWR];
                            cfg_r[c].vSel     <= avsWriteData[C_VSEL];
                            cfg_r[c].iSel     <= avsWriteData[C_ISEL];
                            cfg_r[c].rampDown <= avsWriteData[C_RAMP];
                            cfg_r[c].restore  <= avsWriteData[C_RST];
                        end else if (avsAddress[4:0] == F_TRIPT) begin
                            cfg_r[c].tripTime <= avsWriteData[15:0];
                        end
                    end
                end
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (tripped_r[c]) begin
                    cfg_r[c].pwr <= 1'b0;
                end
            end
        end
    end

    // Factory preset is read-only, no write path reaches it
    always_ff @(posedge clk_sys) begin
        presetV_r <= PRESET_V; // RULE_18
    end

    // Sticky events: [5:0] trip per channel, [6] over-temp; read clears, set wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqSt_r   <= '0;
            irqMask_r <= '0;
        end else begin
            // Read clears, an event in the same cycle survives
            if (avsRead && !ack_r && avsAddress == A_IRQ) begin
                irqSt_r <= {1'b0, overTemp, tripNew};
            end else begin
                irqSt_r <= irqSt_r | {1'b0, overTemp, tripNew};
            end
            if (avsWrite && !ack_r && avsAddress == A_MASK) begin
                irqMask_r <= avsWriteData[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        irq <= rst ? 1'b0 : |(irqSt_r & irqMask_r);
    end

    // Slave answers one cycle after the request, wait low for one edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avsRead || avsWrite) && !ack_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        avsWaitRequest <= rst ? 1'b1 : !((avsRead || avsWrite) && !ack_r);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avsReadData <= '0;
        end else if (avsRead && !ack_r) begin
            if (avsAddress == A_STATUS) begin
                avsReadData <= {16'h0000, overTemp, ilkSync_r[1], tripped_r, 2'b00, chanOn};
            end else if (avsAddress == A_IRQ) begin
                avsReadData <= {24'h000000, irqSt_r};
            end else if (avsAddress == A_MASK) begin
                avsReadData <= {24'h000000, irqMask_r};
            end else if (avsAddress == A_TEMP_LIM) begin
                avsReadData <= {high_temperature_threshold_r, low_temperature_threshold_r};
            end else if (avsAddress == A_BUS_CFG) begin
                avsReadData <= 32'(busCfg_r);
            end else if (avsAddress == A_PRESET) begin
                avsReadData <= {16'h0000, presetV_r};
            end else if (avsAddress >= CH_BASE && avsAddress[4:0] == F_CTRL) begin
                avsReadData <= {16'h0000, vOut_r[chIdx(avsAddress)]};
            end else if (avsAddress >= CH_BASE && avsAddress[4:0] == F_VSET_A) begin
                avsReadData <= {16'h0000, cfg_r[chIdx(avsAddress)].vsetA};
            end else if (avsAddress >= CH_BASE && avsAddress[4:0] == F_VSET_B) begin
                avsReadData <= {16'h0000, cfg_r[chIdx(avsAddress)].vsetB};
            end else if (avsAddress >= CH_BASE && avsAddress[4:0] == F_CEIL) begin
                avsReadData <= {16'h0000, cfg_r[chIdx(avsAddress)].ceil};
            end else begin
                avsReadData <= UNMAPPED_RD;
            end
        end
    end
endmodule
`default_nettype wire

// ===== ctp_channel_ctrl_assertions.sv
// Port-level checks for the channel trip and power control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ctp_channel_ctrl_assertions
    import ctp_pkg::*;
(
    input wire logic                 clk_sys,        // Clock
    input wire logic                 rst,            // Sync reset
    input wire logic [7:0]           avsAddress,     // Address
    input wire logic                 avsRead,        // Read request
    input wire logic                 avsWrite,       // Write request
    input wire logic [31:0]          avsWriteData,   // Write data
    input wire logic [3:0]           avsByteEnable,  // Byte enables
    input wire logic [31:0]          avsReadData,    // Read data
    input wire logic                 avsWaitRequest, // Wait request
    input wire logic                 interlockIn,    // Interlock
    input wire logic [NUM_CH-1:0]    chanEnableIn,   // Enables
    input wire logic [NUM_CH-1:0]    overCurrentIn,  // Over-current
    input wire logic [VW-1:0]        tempIn,         // Temperature
    input wire logic [NUM_CH*VW-1:0] voltageTarget,  // Voltages
    input wire logic [NUM_CH*VW-1:0] currentLimit,   // Limits
    input wire logic [NUM_CH-1:0]    chanOn,         // Channel on
    input wire logic [NUM_LINES-1:0] tripLines,      // Trip bus
    input wire logic                 overTemp,       // Over-temperature
    input wire logic                 irq             // Interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [VW-1:0] v0;
    assign v0 = voltageTarget[VW-1:0];

    a_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low for two cycles");
    a_wait_cause: assert property (!avsWaitRequest |-> $past(avsRead) || $past(avsWrite))
        else $error("waitrequest low without a request");
    a_wait_answer: assert property ((avsRead || avsWrite) |-> ##[0:2] !avsWaitRequest)
        else $error("request not answered in time");
    a_rdata_hold: assert property (!avsRead |=> $stable(avsReadData))
        else $error("read data moved without a read");
    a_ilk_off: assert property (interlockIn [*5] |-> chanOn == '0)
        else $error("channel on while interlock active");
    a_enable_off: assert property ((chanEnableIn == '0) [*5] |-> chanOn == '0)
        else $error("channel on while not enabled");
    // Steps come once per microsecond tick, so no two changes in a row
    a_ramp_step: assert property ($changed(v0) && chanOn[0] |=> ($stable(v0) || !chanOn[0]) [*4])
        else $error("voltage stepped faster than the tick");
    a_off_no_rise: assert property (!chanOn[0] |=> v0 <= $past(v0))
        else $error("voltage rose on an off channel");
endmodule
bind ctp_channel_ctrl ctp_channel_ctrl_assertions i_ctp_channel_ctrl_assertions (
    .clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .interlockIn(interlockIn), .chanEnableIn(chanEnableIn),
    .overCurrentIn(overCurrentIn), .tempIn(tempIn), .voltageTarget(voltageTarget),
    .currentLimit(currentLimit), .chanOn(chanOn), .tripLines(tripLines), .overTemp(overTemp), .irq(irq)
);
`default_nettype wire

// ===== ctp_channel_ctrl_tb_top.sv
// Self-checking bench for the channel trip and power control block.
// Assumes the package register map and one 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module ctp_channel_ctrl_tb_top
    import ctp_pkg::*;
;
    logic                 clk_sys = 1'b0;
    logic                 rst = 1'b1;
    logic [7:0]           avsAddress = 8'h00;
    logic                 avsRead = 1'b0;
    logic                 avsWrite = 1'b0;
    logic [31:0]          avsWriteData = 32'h0;
    logic [31:0]          avsReadData;
    logic                 avsWaitRequest;
    logic                 interlockIn = 1'b0;
    logic [NUM_CH-1:0]    chanEnableIn = 6'h3f;
    logic [NUM_CH-1:0]    overCurrentIn = 6'h00;
    logic [VW-1:0]        tempIn = 16'h0030;
    logic [NUM_CH*VW-1:0] voltageTarget;
    logic [NUM_CH*VW-1:0] currentLimit;
    logic [NUM_CH-1:0]    chanOn;
    logic [NUM_LINES-1:0] tripLines;
    logic                 overTemp;
    logic                 irq;
    logic                 irqA;
    logic [31:0]          rd;
    logic [VW-1:0]        vs;
    logic [VW-1:0]        ia;
    logic [VW-1:0]        ib;
    logic [VW-1:0]        t;
    int                   n_fail = 0;
    int                   num_checks = 0;
    int                   n;

    always #4 clk_sys = ~clk_sys;

    ctp_channel_ctrl i_ctp_channel_ctrl (
        .clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(4'hf), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .interlockIn(interlockIn), .chanEnableIn(chanEnableIn),
        .overCurrentIn(overCurrentIn), .tempIn(tempIn), .voltageTarget(voltageTarget),
        .currentLimit(currentLimit), .chanOn(chanOn), .tripLines(tripLines), .overTemp(overTemp), .irq(irq)
    );

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; holds the request until waitrequest is low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWriteData <= d;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avsWaitRequest !== 1'b0 && k < 40);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clk_sys);
        if (k >= 40) begin
            n_fail++;
            complete_run();
        end
    endtask

    function automatic logic [7:0] ca(input int ch, input logic [4:0] f);
        return CH_BASE + 8'(ch) * CH_STRIDE + {3'h0, f};
    endfunction

    function automatic logic [VW-1:0] vt(input int ch);
        return voltageTarget[ch*VW +: VW];
    endfunction

    // Window set below to 0x10..0x50
    function automatic logic ot_exp(input logic [VW-1:0] tv);
        return tv < 16'h0010 || tv > 16'h0050;
    endfunction

    initial begin
        void'($urandom(37));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        xfer(1'b0, A_BUS_CFG, 32'h0);
        chk(rd, 32'h0);
        chk(32'(tripLines), 32'h0);
        xfer(1'b0, 8'h30, 32'h0);
        chk(rd, UNMAPPED_RD);
        vs = VW'(($urandom % 8 + 4) * 4);
        ia = 16'($urandom);
        ib = 16'($urandom);
        xfer(1'b1, ca(0, F_ILIM_A), 32'(ia));
        xfer(1'b1, ca(0, F_ILIM_B), 32'(ib));
        xfer(1'b1, ca(0, F_VSET_A), 32'(vs));
        xfer(1'b1, ca(0, F_CEIL), 32'h0000_ffff);
        xfer(1'b1, ca(0, F_RATES), 32'h0004_0004);
        xfer(1'b1, ca(0, F_CTRL), 32'h5);
        chk(32'(currentLimit[VW-1:0]), 32'(ib));
        for (n = 0; n < 4000 && vt(0) !== vs; n++) @(posedge clk_sys);
        chk(32'(vt(0)), 32'(vs));
        chk(32'(n >= (vs / 4 - 1) * TICK_CYCLES), 32'h1);
        xfer(1'b1, ca(0, F_CEIL), 32'h4);
        xfer(1'b0, ca(0, F_VSET_A), 32'h0);
        chk(rd, 32'h4);
        for (n = 0; n < 4000 && vt(0) !== 16'h4; n++) @(posedge clk_sys);
        chk(32'(vt(0)), 32'h4);
        chk(32'(n >= (vs / 4 - 3) * TICK_CYCLES), 32'h1);
        xfer(1'b1, ca(0, F_CTRL), 32'h3);
        chk(32'(currentLimit[VW-1:0]), 32'(ia));
        xfer(1'b1, ca(0, F_CTRL), 32'h1);
        // Line 0: ch0 drives, ch3 senses, ch4 both; ch1 stays unconnected
        xfer(1'b1, A_BUS_CFG, 32'h0308_0001);
        xfer(1'b0, A_BUS_CFG, 32'h0);
        chk(rd, 32'h0308_0001);
        xfer(1'b1, ca(0, F_TRIPT), 32'h2);
        for (int c = 3; c < 5; c++) begin
            xfer(1'b1, ca(c, F_VSET_A), 32'(vs));
            xfer(1'b1, ca(c, F_CEIL), 32'h0000_ffff);
            xfer(1'b1, ca(c, F_RATES), 32'h0001_0004);
            xfer(1'b1, ca(c, F_CTRL), (c == 3) ? 32'h9 : 32'h1);
        end
        for (n = 0; n < 4000 && vt(4) !== vs; n++) @(posedge clk_sys);
        overCurrentIn <= 6'h01;
        repeat (100) @(posedge clk_sys);
        chk(32'(chanOn[0]), 32'h1);
        for (n = 0; n < 1000 && chanOn[0] !== 1'b0; n++) @(posedge clk_sys);
        chk(32'(chanOn[0]), 32'h0);
        for (n = 0; n < TRIP_MAX_CYC && chanOn[4:3] !== 2'b00; n++) @(posedge clk_sys);
        chk(32'(chanOn[4:3]), 32'h0);
        chk(32'(tripLines), 32'h1);
        repeat (2) @(posedge clk_sys);
        chk(32'(vt(4)), 32'h0);
        chk(32'(vt(3) != 16'h0), 32'h1);
        overCurrentIn <= 6'h00;
        xfer(1'b1, A_TEMP_LIM, 32'h0050_0010);
        for (int i = 0; i < 8; i++) begin
            t = 16'($urandom % 128);
            t = (t == 16'h10 || t == 16'h50) ? 16'h60 : t;
            tempIn <= (i == 7) ? 16'h60 : t;
            repeat (6) @(posedge clk_sys);
            chk(32'(overTemp), 32'(ot_exp((i == 7) ? 16'h60 : t)));
        end
        xfer(1'b1, A_MASK, 32'h7f);
        irqA = irq;
        xfer(1'b1, A_MASK, 32'h0);
        chk(32'(irqA), 32'h1);
        chk(32'(irq), 32'h0);
        xfer(1'b0, A_IRQ, 32'h0);
        chk(32'(rd[6]), 32'h1);
        tempIn <= 16'h0030;
        repeat (6) @(posedge clk_sys);
        xfer(1'b0, A_IRQ, 32'h0);
        xfer(1'b0, A_IRQ, 32'h0);
        chk(32'(rd[6]), 32'h0);
        xfer(1'b1, A_PRESET, 32'hffff_ffff);
        xfer(1'b0, A_PRESET, 32'h0);
        chk(rd, 32'(PRESET_V));
        xfer(1'b1, ca(1, F_CTRL), 32'h11);
        xfer(1'b1, ca(2, F_CTRL), 32'h01);
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(32'(chanOn[2:1]), 32'h1);
        interlockIn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(32'(chanOn), 32'h0);
        interlockIn <= 1'b0;
        chanEnableIn <= 6'h00;
        xfer(1'b1, ca(1, F_CTRL), 32'h1);
        repeat (8) @(posedge clk_sys);
        chk(32'(chanOn), 32'h0);
        chanEnableIn <= 6'h3f;
        xfer(1'b1, ca(1, F_CTRL), 32'h1);
        repeat (8) @(posedge clk_sys);
        chk(32'(chanOn[1]), 32'h1);
        complete_run();
    end
endmodule
`default_nettype wire

// ===== ctp_pkg.sv
// Package for the channel trip and power control block.
// Assumes a single 125 MHz system clock and a 32-bit Avalon-MM register bus.
package ctp_pkg;
    localparam int NUM_CH        = 6;
    localparam int NUM_LINES     = NUM_CH / 2;
    localparam int VW            = 16;
    localparam int CLK_MHZ       = 125;
    localparam int TICK_US       = 1;
    localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;
    localparam int TRIP_MAX_MS   = 1;
    localparam int TRIP_MAX_CYC  = TRIP_MAX_MS * 1000 * CLK_MHZ;

    // Per-channel word offsets: byte address = CH_BASE + ch*CH_STRIDE + field
    localparam logic [7:0] CH_BASE    = 8'h40;
    localparam logic [7:0] CH_STRIDE  = 8'h20;
    localparam logic [4:0] F_VSET_A   = 5'h00;
    localparam logic [4:0] F_VSET_B   = 5'h04;
    localparam logic [4:0] F_ILIM_A   = 5'h08;
    localparam logic [4:0] F_ILIM_B   = 5'h0c;
    localparam logic [4:0] F_CEIL     = 5'h10;
    localparam logic [4:0] F_RATES    = 5'h14;
    localparam logic [4:0] F_CTRL     = 5'h18;
    localparam logic [4:0] F_TRIPT    = 5'h1c;

    // Board-level registers
    localparam logic [7:0] A_STATUS   = 8'h00;
    localparam logic [7:0] A_IRQ      = 8'h04;
    localparam logic [7:0] A_MASK     = 8'h08;
    localparam logic [7:0] A_TEMP_LIM = 8'h0c;
    localparam logic [7:0] A_BUS_CFG  = 8'h10;
    localparam logic [7:0] A_PRESET   = 8'h14;

    // Control word bit positions
    localparam int C_PWR   = 0;
    localparam int C_VSEL  = 1;
    localparam int C_ISEL  = 2;
    localparam int C_RAMP  = 3;
    localparam int C_RST   = 4;

    localparam logic [31:0] UNMAPPED_RD = 32'hdead_beef;
    localparam logic [VW-1:0] PRESET_V  = 16'h0000;

    typedef enum logic [1:0] {
        TB_NONE  = 2'h0,
        TB_DRIVE = 2'h1,
        TB_SENSE = 2'h2,
        TB_BOTH  = 2'h3
    } ctp_tbmode_type;

    typedef struct packed {
        logic [VW-1:0] vsetA;
        logic [VW-1:0] vsetB;
        logic [VW-1:0] ilimA;
        logic [VW-1:0] ilimB;
        logic [VW-1:0] ceil;
        logic [VW-1:0] riseRate;
        logic [VW-1:0] fallRate;
        logic [VW-1:0] tripTime;
        logic          pwr;
        logic          vSel;
        logic          iSel;
        logic          rampDown;
        logic          restore;
    } ctp_chcfg_type;
endpackage
